//--- src/sdl_loader.sv
// Serial front end of a multi-channel 10-bit DAC: shift, decode, latch
`timescale 1ns/1ns
`default_nettype none
module sdl_loader #(
  parameter int NCH = sdl_pkg::NCH_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic reset_pin_n,
  input wire logic bit_order_lsb,
  output wire logic serial_out,
  output var logic [NCH*sdl_pkg::CODE_W-1:0] analog_out_codes
);
  localparam int CW = sdl_pkg::CODE_W;
  localparam int FW = sdl_pkg::FRAME_W;
  localparam logic [sdl_pkg::ADDR_W-1:0] ADDR_LAST =
    sdl_pkg::ADDR_W'(NCH);

  logic [sdl_pkg::PIN_W-1:0] pins_raw;
  logic [sdl_pkg::PIN_W-1:0] pins_s;
  logic sclk_s;
  logic sdin_s;
  logic load_s;
  logic rstpin_n_s;
  logic order_lsb_s;
  logic sclk_prev_r;
  logic sclk_rise;
  logic [FW-1:0] sr_r;
  logic [sdl_pkg::ADDR_W-1:0] addr;
  logic [CW-1:0] field;
  logic [CW-1:0] code_in;
  logic addr_ok;

  assign pins_raw = {bit_order_lsb, reset_pin_n, load_strobe, serial_in,
                     shift_clk};

  sdl_sync #(
    .W(sdl_pkg::PIN_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_in(pins_raw),
    .d_out(pins_s)
  );

  assign sclk_s = pins_s[sdl_pkg::PIN_SCLK];
  assign sdin_s = pins_s[sdl_pkg::PIN_SDIN];
  assign load_s = pins_s[sdl_pkg::PIN_LOAD];
  assign rstpin_n_s = pins_s[sdl_pkg::PIN_RSTN];
  assign order_lsb_s = pins_s[sdl_pkg::PIN_ORDER];

  // Edge finder on the synchronised shift clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_r;

  // New bit enters at the top; first bit sent ends at bit 0
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sr_r <= sdl_pkg::SR_RESET;
    end
    else if (sclk_rise)
    begin
      sr_r <= {sdin_s, sr_r[FW-1:1]};
    end
  end

  // Reset pin does not touch the shift register
  assign serial_out = sr_r[0];

  // Word split into address and code
  assign addr = sr_r[sdl_pkg::ADDR_LSB +: sdl_pkg::ADDR_W];
  assign field = sr_r[sdl_pkg::CODE_LSB +: CW];
  assign code_in = order_lsb_s ? field : sdl_pkg::bit_rev(field);
  assign addr_ok = (addr >= sdl_pkg::ADDR_FIRST) && (addr <= ADDR_LAST);

  // One output latch per channel; reset pin wins over load
  always_ff @(posedge clk_sys)
  begin
    for (int k = 0; k < NCH; k++)
    begin
      if (!rst_n || !rstpin_n_s)
      begin
        analog_out_codes[k*CW +: CW] <= sdl_pkg::CODE_RESET;
      end
      else if (load_s && addr == sdl_pkg::ADDR_W'(k + 1))
      begin
        // Level load: a shift during load passes straight through
        analog_out_codes[k*CW +: CW] <= code_in;
      end
    end
  end

  // Per-channel checks
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    localparam logic [sdl_pkg::ADDR_W-1:0] MY_ADDR =
      sdl_pkg::ADDR_W'(g + 1);

    AST_CH_KEEP: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (rstpin_n_s && !(load_s && addr == MY_ADDR))
      |=> $stable(analog_out_codes[g*CW +: CW]))
      else $error("channel changed while not addressed");

    AST_LOAD_CH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (load_s && rstpin_n_s && addr == MY_ADDR)
      |=> analog_out_codes[g*CW +: CW] == $past(code_in))
      else $error("addressed channel did not take the code");

    AST_MSB_FIRST: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (load_s && rstpin_n_s && !order_lsb_s && addr == MY_ADDR)
      |=> analog_out_codes[g*CW +: CW] == sdl_pkg::bit_rev($past(field)))
      else $error("order pin low did not give msb first code");

    AST_LSB_FIRST: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (load_s && rstpin_n_s && order_lsb_s && addr == MY_ADDR)
      |=> analog_out_codes[g*CW +: CW] == $past(field))
      else $error("order pin high did not give lsb first code");
  end

  // Checks
  sequence seq_shift_edge;
    sclk_rise;
  endsequence

  sequence seq_load_bad;
    load_s && rstpin_n_s && !addr_ok;
  endsequence

  sequence seq_idle;
    !load_s && rstpin_n_s;
  endsequence

  AST_SHIFT_IN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_shift_edge |=> sr_r == {$past(sdin_s), $past(sr_r[FW-1:1])})
    else $error("shift register did not take the serial bit");

  AST_SHIFT_HOLD: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !sclk_rise |=> $stable(sr_r))
    else $error("shift register moved without a clock rise");

  AST_SOUT_ORDER: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    seq_shift_edge |=> serial_out == $past(sr_r[1]))
    else $error("serial output did not follow shift order");

  AST_RESET_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rstpin_n_s |=> analog_out_codes == '0)
    else $error("reset pin did not clear every channel");

  AST_RESET_KEEPS_SR: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (!rstpin_n_s && !sclk_rise) |=> sr_r == $past(sr_r))
    else $error("reset pin disturbed the shift register");

  AST_BAD_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_load_bad |=> $stable(analog_out_codes))
    else $error("unused address changed a channel");

  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_idle ##1 seq_idle |-> $stable(analog_out_codes))
    else $error("channel changed without load or reset");

  // Raw pin edges, two flops ahead of the logic
  sequence seq_sclk_pin_up;
    !shift_clk ##1 shift_clk;
  endsequence

  sequence seq_load_pin_up;
    !load_strobe ##1 load_strobe;
  endsequence

  sequence seq_rst_pin_down;
    reset_pin_n ##1 !reset_pin_n;
  endsequence

  AST_PIPE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_sclk_pin_up |-> ##2 sclk_rise)
    else $error("shift clock edge not seen after two stages");

  AST_LOAD_PIPE: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    seq_load_pin_up |-> ##2 load_s)
    else $error("load pin not seen after two stages");

  AST_RSTPIN_PIPE: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    seq_rst_pin_down |-> ##2 !rstpin_n_s)
    else $error("reset pin not seen after two stages");

  AST_SOUT_KEEP: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !sclk_rise |=> $stable(serial_out))
    else $error("serial output moved without a clock rise");
endmodule // sdl_loader
`default_nettype wire

//--- src/sdl_pkg.sv
// Constants and helpers shared by the serial DAC loader
package sdl_pkg;
  localparam int FRAME_W = 14;
  localparam int ADDR_W = 4;
  localparam int CODE_W = 10;
  localparam int ADDR_LSB = 0;
  localparam int CODE_LSB = 4;
  localparam int NCH_DEF = 10;
  localparam int NCH_ALT = 8;
  localparam int PIN_W = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDIN = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_RSTN = 3;
  localparam int PIN_ORDER = 4;
  localparam logic [FRAME_W-1:0] SR_RESET = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'h1;
  localparam logic [PIN_W-1:0] PIN_RESET = 5'h00;
  // Host shift clock ceiling and its spacing in system cycles
  localparam int SHIFT_FMAX_MHZ = 10;
  localparam int SHIFT_PERIOD_MIN_NS = 1000 / SHIFT_FMAX_MHZ;
  localparam int SYS_CLK_MHZ = 25;
  localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int SHIFT_PERIOD_MIN_CYC =
    (SHIFT_PERIOD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  function automatic logic [CODE_W-1:0] bit_rev(input logic [CODE_W-1:0] v);
    logic [CODE_W-1:0] r;
    r = '0;
    for (int i = 0; i < CODE_W; i++)
    begin
      r[i] = v[CODE_W-1-i];
    end
    return r;
  endfunction
endpackage

//--- src/sdl_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module sdl_sync #(
  parameter int W = sdl_pkg::PIN_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d_in,
  output var logic [W-1:0] d_out
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage1_r <= W'(sdl_pkg::PIN_RESET);
      d_out <= W'(sdl_pkg::PIN_RESET);
    end
    else
    begin
      stage1_r <= d_in;
      d_out <= stage1_r;
    end
  end
endmodule // sdl_sync
`default_nettype wire

//--- verif/sdl_host.sv
// Host model driving the three-wire serial link
`timescale 1ns/1ns
`default_nettype none
module sdl_host (
  output var logic shift_clk,
  output var logic serial_in,
  output var logic load_strobe
);
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
  end
  // D0 first, 320 ns period; data line inverted once released
  task automatic send(input logic [13:0] w);
    for (int i = 0; i < 14; i++)
    begin
      serial_in = w[i];
      #160 shift_clk = 1'b1;
      #160 shift_clk = 1'b0;
    end
    serial_in = ~serial_in;
  endtask
  // Shift clock held still while load is high
  task automatic load();
    #160 load_strobe = 1'b1;
    #320 load_strobe = 1'b0;
    #160;
  endtask
endmodule // sdl_host
`default_nettype wire

//--- verif/serial_multichannel_dac_loader_tb.sv
// Self-checking bench for the serial DAC loader
`timescale 1ns/1ns
`default_nettype none
module serial_multichannel_dac_loader_tb;
  localparam int NCH = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic bit_order_lsb = 1'b1;
  wire logic shift_clk;
  wire logic serial_in;
  wire logic load_strobe;
  wire logic serial_out;
  logic [NCH*10-1:0] codes;
  logic [9:0] exp_q [1:NCH];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  sdl_host sdl_host_inst (.shift_clk(shift_clk), .serial_in(serial_in),
    .load_strobe(load_strobe));
  sdl_loader #(.NCH(NCH)) sdl_loader_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .shift_clk(shift_clk), .serial_in(serial_in),
    .load_strobe(load_strobe), .reset_pin_n(reset_pin_n),
    .bit_order_lsb(bit_order_lsb), .serial_out(serial_out),
    .analog_out_codes(codes));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_all();
    for (int k = 1; k <= NCH; k++)
      chk(codes[(k-1)*10 +: 10], exp_q[k]);
  endtask
  // One frame then a load; code reversed when sent MSB first
  task automatic wr(input logic [3:0] a, input logic [9:0] c,
    input logic lsb);
    logic [9:0] r;
    r = {<<{c}};
    @(negedge clk_sys) bit_order_lsb = lsb;
    sdl_host_inst.send({(lsb ? c : r), a});
    sdl_host_inst.load();
    if (a >= 1 && a <= NCH)
      exp_q[a] = c;
  endtask
  task automatic t_lsb();
    wr(4'hA, 10'h3FF, 1'b1);
    wr(4'h1, 10'h2A5, 1'b1);
    chk_all();
    chk({9'h000, serial_out}, 10'h001);
  endtask
  task automatic t_msb();
    wr(4'h3, 10'h001, 1'b0);
    wr(4'h4, 10'h2C0, 1'b0);
    chk_all();
    chk({9'h000, serial_out}, 10'h000);
  endtask
  task automatic t_unmapped();
    wr(4'h0, 10'h155, 1'b1);
    wr(4'hB, 10'h0F0, 1'b1);
    wr(4'hF, 10'h333, 1'b1);
    chk_all();
  endtask
  // Frame shifted, pin reset, then a bare load reuses the word
  task automatic t_pin();
    sdl_host_inst.send({10'h1C3, 4'h5});
    @(negedge clk_sys) reset_pin_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    exp_q = '{default: 10'h000};
    chk_all();
    sdl_host_inst.load();
    exp_q[5] = 10'h1C3;
    chk_all();
  endtask
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    exp_q = '{default: 10'h000};
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_all();
    t_lsb();
    t_msb();
    t_unmapped();
    t_pin();
    summarize();
  end
endmodule // serial_multichannel_dac_loader_tb
`default_nettype wire
